// File: design/prcr_pkg.sv
// constants, carriers and states of the power result and control register bank
// Operation
// - instantaneous reactive power is current times 90-degree shifted voltage, at address 21
// - average reactive power at address 20 is instantaneous reactive mean over N samples
// - averaging length N is the currently programmed cycle count, or one when that count is zero
// - reactive results are signed 24-bit fractions from minus one to below one
// - peak registers 22 and 23 hold largest magnitude sample of last cycle
// - trigonometric reactive power at address 24 is an unsigned fraction below one
// - power factor at address 25 is active over apparent power, signed fraction
// - apparent power at address 27 is rms voltage times rms current, MSB zero
// - control bit 8 set aborts a running auto-boot; reset value zero is normal
// - control bit 4 set makes the interrupt output open drain; zero drives normally
// - interrupt asserts when any status flag is set with its mask bit one
// - control bit 2 set stops the processor clock output pin
// - control bit 1 set disables the crystal oscillator
// - harmonic active power at 29 is total minus fundamental active power
// - fundamental active power at 30 is product of line-frequency DFT results
// - fundamental reactive power at 31 is read-only and DFT derived
package prcr_pkg;

    localparam int DW = 24;
    localparam int AW = 5;

    // ==========================================================
    // register addresses
    localparam logic [AW-1:0] ADDR_REACT_AVG = 5'h14;
    localparam logic [AW-1:0] ADDR_Q_INST  = 5'h15;
    localparam logic [AW-1:0] ADDR_I_PEAK  = 5'h16;
    localparam logic [AW-1:0] ADDR_V_PEAK  = 5'h17;
    localparam logic [AW-1:0] ADDR_Q_TRIG  = 5'h18;
    localparam logic [AW-1:0] ADDR_PWR_FACTOR = 5'h19;
    localparam logic [AW-1:0] ADDR_S       = 5'h1b;
    localparam logic [AW-1:0] ADDR_CTRL    = 5'h1c;
    localparam logic [AW-1:0] ADDR_P_HARM  = 5'h1d;
    localparam logic [AW-1:0] ADDR_P_FUND  = 5'h1e;
    localparam logic [AW-1:0] ADDR_Q_FUND  = 5'h1f;

    // ==========================================================
    // control fields and reset values
    localparam int CTRL_STOP_BIT  = 8;
    localparam int CTRL_IRQOD_BIT = 4;
    localparam int CTRL_CLKOUT_OFF_BIT = 2;
    localparam int CTRL_XTAL_OFF_BIT   = 1;
    localparam logic [DW-1:0] CTRL_RESET = 24'h000000;
    localparam logic [DW-1:0] CTRL_WMASK = 24'h000116;
    localparam logic [DW-1:0] RESULT_RESET = 24'h000000;
    localparam logic [DW-1:0] FRAC_MAX_POS = 24'h7fffff;

    // ==========================================================
    // cycle counts of the post-cycle arithmetic
    localparam logic [5:0] DIV_STEPS  = 6'h30;
    localparam logic [5:0] SQRT_STEPS = 6'h18;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic [DW-1:0] i_smp;
        logic [DW-1:0] v_smp;
        logic [DW-1:0] v_q90;
    } prcr_sample_t;

    typedef struct packed {
        logic [DW-1:0] v_re;
        logic [DW-1:0] v_im;
        logic [DW-1:0] i_re;
        logic [DW-1:0] i_im;
    } prcr_dft_t;

    typedef struct packed {
        logic          wr;
        logic          rd;
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
    } prcr_reg_req_t;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_AVG,
        SEQ_FAC,
        SEQ_SQRT
    } prcr_seq_t;

endpackage

// File: design/prcr_regs.sv
// power result and control register bank with its result arithmetic
`timescale 1ns/100ps
module prcr_regs
    import prcr_pkg::*;
#(
    parameter int CYC_W   = 24,
    parameter int CLK_DIV = 2
) (
    // clock and reset
    input  wire logic          sys_clk,
    input  wire logic          rst_n,
    // register port
    input  wire prcr_reg_req_t reg_req,
    output logic [DW-1:0]      reg_rdata_ff,
    output logic               reg_rvalid_ff,
    // measurement inputs
    input  wire logic          sample_valid,
    input  wire prcr_sample_t  sample,
    input  wire prcr_dft_t     dft,
    input  wire logic [DW-1:0] active_power,
    input  wire logic [DW-1:0] vrms,
    input  wire logic [DW-1:0] irms,
    input  wire logic [CYC_W-1:0] cycle_count,
    // interrupt sources
    input  wire logic [DW-1:0] status_flags,
    input  wire logic [DW-1:0] status_mask,
    // device pins and controls
    output logic               irq_n_o_ff,
    output logic               irq_n_oe_n_ff,
    output logic               processor_clock_out_pin_ff,
    output logic               xtal_oscillator_disable_ff,
    output logic               autoboot_stop_ff,
    output logic               results_ready_ff
);

    if (CYC_W < 1 || CYC_W > DW) begin
        $error("cycle count width must be 1 to 24");
    end
    if (CLK_DIV < 1 || CLK_DIV > 256) begin
        $error("clock divider must be 1 to 256");
    end

    // ==========================================================
    // fixed point helpers
    function automatic logic [DW-1:0] frac_mul(input logic [DW-1:0] a, input logic [DW-1:0] b);
        logic signed [2*DW-1:0] p;
        p = $signed(a) * $signed(b);
        frac_mul = (a == 24'h800000 && b == 24'h800000) ? FRAC_MAX_POS : p[2*DW-2:DW-1];
    endfunction

    function automatic logic [DW-1:0] frac_sub(input logic [DW-1:0] a, input logic [DW-1:0] b);
        logic signed [DW:0] d;
        d = $signed({a[DW-1], a}) - $signed({b[DW-1], b});
        frac_sub = (d[DW] != d[DW-1]) ? (d[DW] ? 24'h800000 : FRAC_MAX_POS) : d[DW-1:0];
    endfunction

    function automatic logic [DW-1:0] frac_mag(input logic [DW-1:0] a);
        frac_mag = a[DW-1] ? (~a + 24'h000001) : a;
    endfunction

    function automatic logic [DW-1:0] apply_sign(input logic neg, input logic [DW-1:0] m);
        logic [DW-1:0] s;
        s = (m[DW-1] && !neg) ? FRAC_MAX_POS : m;
        apply_sign = neg ? (~s + 24'h000001) : s;
    endfunction

    // ==========================================================
    // computation cycle accumulation
    logic [CYC_W-1:0]  smp_cnt_ff,  nxt_smp_cnt;
    logic [2*DW-1:0]   q_sum_ff,    nxt_q_sum;
    logic [DW-1:0]     i_pk_ff,     nxt_i_pk;
    logic [DW-1:0]     v_pk_ff,     nxt_v_pk;
    logic [DW-1:0]     q_inst_ff,   nxt_q_inst;
    logic [DW-1:0]     i_peak_ff,   nxt_i_peak;
    logic [DW-1:0]     v_peak_ff,   nxt_v_peak;
    logic [DW-1:0]     s_ff,        nxt_s;
    logic [DW-1:0]     p_ff,        nxt_p;
    logic [DW-1:0]     p_fund_ff,   nxt_p_fund;
    logic [DW-1:0]     q_fund_ff,   nxt_q_fund;
    logic [DW-1:0]     p_harm_ff,   nxt_p_harm;
    logic [2*DW-1:0]   sum_snap_ff, nxt_sum_snap;
    logic [CYC_W-1:0]  n_snap_ff,   nxt_n_snap;
    logic              cyc_end_ff,  nxt_cyc_end;

    logic [DW-1:0]     q_now;
    logic [2*DW-1:0]   sum_now;
    logic [CYC_W-1:0]  n_eff;
    logic [DW-1:0]     pfund_now;
    logic [2*DW-1:0]   s_prod;

    always_comb begin
        q_now        = frac_mul(sample.v_q90, sample.i_smp);
        sum_now      = q_sum_ff + {{DW{q_now[DW-1]}}, q_now};
        n_eff        = (cycle_count == '0) ? CYC_W'(1) : cycle_count;
        pfund_now    = frac_mul(dft.v_re, dft.i_re) + frac_mul(dft.v_im, dft.i_im);
        s_prod       = vrms * irms;
        nxt_smp_cnt  = smp_cnt_ff;
        nxt_q_sum    = q_sum_ff;
        nxt_i_pk     = i_pk_ff;
        nxt_v_pk     = v_pk_ff;
        nxt_q_inst   = q_inst_ff;
        nxt_i_peak   = i_peak_ff;
        nxt_v_peak   = v_peak_ff;
        nxt_s        = s_ff;
        nxt_p        = p_ff;
        nxt_p_fund   = p_fund_ff;
        nxt_q_fund   = q_fund_ff;
        nxt_p_harm   = p_harm_ff;
        nxt_sum_snap = sum_snap_ff;
        nxt_n_snap   = n_snap_ff;
        nxt_cyc_end  = 1'b0;
        if (sample_valid) begin
            nxt_q_inst = q_now;
            if (frac_mag(sample.i_smp) > frac_mag(i_pk_ff) || smp_cnt_ff == '0) begin
                nxt_i_pk = sample.i_smp;
            end
            if (frac_mag(sample.v_smp) > frac_mag(v_pk_ff) || smp_cnt_ff == '0) begin
                nxt_v_pk = sample.v_smp;
            end
            if (smp_cnt_ff + CYC_W'(1) >= n_eff) begin
                nxt_i_peak   = nxt_i_pk;
                nxt_v_peak   = nxt_v_pk;
                nxt_s        = {1'b0, s_prod[2*DW-3:DW-1]};
                nxt_p        = active_power;
                nxt_p_fund   = pfund_now;
                nxt_q_fund   = frac_sub(frac_mul(dft.v_im, dft.i_re), frac_mul(dft.v_re, dft.i_im));
                nxt_p_harm   = frac_sub(active_power, pfund_now);
                nxt_sum_snap = sum_now;
                nxt_n_snap   = n_eff;
                nxt_cyc_end  = 1'b1;
                nxt_smp_cnt  = '0;
                nxt_q_sum    = '0;
            end else begin
                nxt_smp_cnt = smp_cnt_ff + CYC_W'(1);
                nxt_q_sum   = sum_now;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            smp_cnt_ff  <= '0;
            q_sum_ff    <= '0;
            i_pk_ff     <= RESULT_RESET;
            v_pk_ff     <= RESULT_RESET;
            q_inst_ff   <= RESULT_RESET;
            i_peak_ff   <= RESULT_RESET;
            v_peak_ff   <= RESULT_RESET;
            s_ff        <= RESULT_RESET;
            p_ff        <= RESULT_RESET;
            p_fund_ff   <= RESULT_RESET;
            q_fund_ff   <= RESULT_RESET;
            p_harm_ff   <= RESULT_RESET;
            sum_snap_ff <= '0;
            n_snap_ff   <= '0;
            cyc_end_ff  <= 1'b0;
        end else begin
            smp_cnt_ff  <= nxt_smp_cnt;
            q_sum_ff    <= nxt_q_sum;
            i_pk_ff     <= nxt_i_pk;
            v_pk_ff     <= nxt_v_pk;
            q_inst_ff   <= nxt_q_inst;
            i_peak_ff   <= nxt_i_peak;
            v_peak_ff   <= nxt_v_peak;
            s_ff        <= nxt_s;
            p_ff        <= nxt_p;
            p_fund_ff   <= nxt_p_fund;
            q_fund_ff   <= nxt_q_fund;
            p_harm_ff   <= nxt_p_harm;
            sum_snap_ff <= nxt_sum_snap;
            n_snap_ff   <= nxt_n_snap;
            cyc_end_ff  <= nxt_cyc_end;
        end
    end

    // ==========================================================
    // post-cycle sequencer: average, power factor, trig reactive power
    prcr_seq_t         seq_ff,    nxt_seq;
    logic [5:0]        step_ff,   nxt_step;
    logic [2*DW-1:0]   num_ff,    nxt_num;
    logic [DW-1:0]     den_ff,    nxt_den;
    logic [DW+1:0]     rem_ff,    nxt_rem;
    logic [2*DW-1:0]   quo_ff,    nxt_quo;
    logic              neg_ff,    nxt_neg;
    logic [DW-1:0]     react_avg_ff, nxt_react_avg;
    logic [DW-1:0]     pwr_fac_ff,   nxt_pwr_fac;
    logic [DW-1:0]     q_trig_ff, nxt_q_trig;
    logic              ready_ff,  nxt_ready;

    logic [DW+1:0]     rem_sh;
    logic [DW+1:0]     trial;
    logic              q_bit;
    logic [DW-1:0]     quo_sat;
    logic [2*DW-1:0]   s_sq;
    logic [2*DW-1:0]   p_sq;

    always_comb begin
        nxt_seq    = seq_ff;
        nxt_step   = step_ff;
        nxt_num    = num_ff;
        nxt_den    = den_ff;
        nxt_rem    = rem_ff;
        nxt_quo    = quo_ff;
        nxt_neg    = neg_ff;
        nxt_react_avg = react_avg_ff;
        nxt_pwr_fac   = pwr_fac_ff;
        nxt_q_trig = q_trig_ff;
        nxt_ready  = 1'b0;
        s_sq       = s_ff * s_ff;
        p_sq       = frac_mag(p_ff) * frac_mag(p_ff);
        quo_sat    = (quo_ff[2*DW-1:DW] != '0) ? FRAC_MAX_POS : quo_ff[DW-1:0];
        // square root takes two numerator bits per step, division one
        rem_sh = (seq_ff == SEQ_SQRT) ? {rem_ff[DW-1:0], num_ff[2*DW-1:2*DW-2]} : {rem_ff[DW:0], num_ff[2*DW-1]};
        trial  = (seq_ff == SEQ_SQRT) ? {quo_ff[DW-1:0], 2'b01} : {2'b00, den_ff};
        q_bit = (rem_sh >= trial);
        unique case (seq_ff)
            SEQ_IDLE: begin
                if (cyc_end_ff) begin
                    nxt_seq  = SEQ_AVG;
                    nxt_step = '0;
                    nxt_num  = sum_snap_ff[2*DW-1] ? (~sum_snap_ff + 48'h000000000001) : sum_snap_ff;
                    nxt_den  = DW'(n_snap_ff);
                    nxt_neg  = sum_snap_ff[2*DW-1];
                    nxt_rem  = '0;
                    nxt_quo  = '0;
                end
            end
            SEQ_AVG, SEQ_FAC: begin
                nxt_rem  = q_bit ? (rem_sh - trial) : rem_sh;
                nxt_quo  = {quo_ff[2*DW-2:0], q_bit};
                nxt_num  = {num_ff[2*DW-2:0], 1'b0};
                nxt_step = step_ff + 6'h01;
                if (step_ff == DIV_STEPS) begin
                    nxt_rem  = '0;
                    nxt_quo  = '0;
                    nxt_step = '0;
                    if (seq_ff == SEQ_AVG) begin
                        nxt_react_avg = apply_sign(neg_ff, quo_ff[DW-1:0]);
                        nxt_seq       = SEQ_FAC;
                        nxt_num   = {1'b0, frac_mag(p_ff), 23'h000000};
                        nxt_den   = s_ff;
                        nxt_neg   = p_ff[DW-1];
                    end else begin
                        nxt_pwr_fac = (s_ff == '0) ? RESULT_RESET : apply_sign(neg_ff, quo_sat);
                        nxt_seq    = SEQ_SQRT;
                        nxt_num    = (s_sq > p_sq) ? (s_sq - p_sq) : '0;
                    end
                end
            end
            SEQ_SQRT: begin
                nxt_rem  = q_bit ? (rem_sh - trial) : rem_sh;
                nxt_quo  = {quo_ff[2*DW-2:0], q_bit};
                nxt_num  = {num_ff[2*DW-3:0], 2'b00};
                nxt_step = step_ff + 6'h01;
                if (step_ff == SQRT_STEPS) begin
                    nxt_q_trig = quo_ff[DW-1:0];
                    nxt_seq    = SEQ_IDLE;
                    nxt_step   = '0;
                    nxt_rem    = '0;
                    nxt_quo    = '0;
                    nxt_ready  = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            seq_ff    <= SEQ_IDLE;
            step_ff   <= '0;
            num_ff    <= '0;
            den_ff    <= '0;
            rem_ff    <= '0;
            quo_ff    <= '0;
            neg_ff    <= 1'b0;
            react_avg_ff <= RESULT_RESET;
            pwr_fac_ff   <= RESULT_RESET;
            q_trig_ff <= RESULT_RESET;
            ready_ff  <= 1'b0;
        end else begin
            seq_ff    <= nxt_seq;
            step_ff   <= nxt_step;
            num_ff    <= nxt_num;
            den_ff    <= nxt_den;
            rem_ff    <= nxt_rem;
            quo_ff    <= nxt_quo;
            neg_ff    <= nxt_neg;
            react_avg_ff <= nxt_react_avg;
            pwr_fac_ff   <= nxt_pwr_fac;
            q_trig_ff <= nxt_q_trig;
            ready_ff  <= nxt_ready;
        end
    end

    // ==========================================================
    // register port, control register and pins
    logic [DW-1:0]     ctrl_ff,    nxt_ctrl;
    logic [DW-1:0]     nxt_rdata;
    logic              nxt_rvalid;
    logic [7:0]        div_ff,     nxt_div;
    logic              nxt_cpu_clk;
    logic              irq_act;

    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (reg_req.wr && reg_req.addr == ADDR_CTRL) begin
            nxt_ctrl = reg_req.wdata & CTRL_WMASK;
        end
        nxt_rvalid = reg_req.rd;
        nxt_rdata  = reg_rdata_ff;
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                ADDR_REACT_AVG:  nxt_rdata = react_avg_ff;
                ADDR_Q_INST: nxt_rdata = q_inst_ff;
                ADDR_I_PEAK: nxt_rdata = i_peak_ff;
                ADDR_V_PEAK: nxt_rdata = v_peak_ff;
                ADDR_Q_TRIG: nxt_rdata = q_trig_ff;
                ADDR_PWR_FACTOR: nxt_rdata = pwr_fac_ff;
                ADDR_S:      nxt_rdata = s_ff;
                ADDR_CTRL:   nxt_rdata = ctrl_ff;
                ADDR_P_HARM: nxt_rdata = p_harm_ff;
                ADDR_P_FUND: nxt_rdata = p_fund_ff;
                ADDR_Q_FUND: nxt_rdata = q_fund_ff;
                default:     nxt_rdata = RESULT_RESET;
            endcase
        end
        irq_act     = |(status_flags & status_mask);
        nxt_div     = div_ff + 8'h01;
        nxt_cpu_clk = processor_clock_out_pin_ff;
        if (div_ff == 8'(CLK_DIV - 1)) begin
            nxt_div     = '0;
            nxt_cpu_clk = ~processor_clock_out_pin_ff;
        end
        if (ctrl_ff[CTRL_CLKOUT_OFF_BIT]) begin
            nxt_cpu_clk = 1'b0;
            nxt_div     = '0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff                    <= CTRL_RESET;
            reg_rdata_ff               <= RESULT_RESET;
            reg_rvalid_ff              <= 1'b0;
            div_ff                     <= '0;
            processor_clock_out_pin_ff <= 1'b0;
            irq_n_o_ff                 <= 1'b1;
            irq_n_oe_n_ff              <= 1'b0;
            xtal_oscillator_disable_ff <= 1'b0;
            autoboot_stop_ff           <= 1'b0;
            results_ready_ff           <= 1'b0;
        end else begin
            ctrl_ff                    <= nxt_ctrl;
            reg_rdata_ff               <= nxt_rdata;
            reg_rvalid_ff              <= nxt_rvalid;
            div_ff                     <= nxt_div;
            processor_clock_out_pin_ff <= nxt_cpu_clk;
            // open drain: drive low only while asserted, else release
            irq_n_o_ff                 <= ctrl_ff[CTRL_IRQOD_BIT] ? 1'b0 : ~irq_act;
            irq_n_oe_n_ff              <= ctrl_ff[CTRL_IRQOD_BIT] ? ~irq_act : 1'b0;
            xtal_oscillator_disable_ff <= ctrl_ff[CTRL_XTAL_OFF_BIT];
            autoboot_stop_ff           <= ctrl_ff[CTRL_STOP_BIT];
            results_ready_ff           <= ready_ff;
        end
    end

endmodule

// File: tb/prcr_regs_asserts.sv
// assertion checker for the power result and control register bank
`timescale 1ns/100ps
module prcr_regs_asserts
    import prcr_pkg::*;
#(
    parameter int CYC_W   = 24,
    parameter int CLK_DIV = 2
) (
    // clock and reset
    input wire logic          sys_clk,
    input wire logic          rst_n,
    // register port
    input wire prcr_reg_req_t reg_req,
    input wire logic [DW-1:0] reg_rdata_ff,
    input wire logic          reg_rvalid_ff,
    // interrupt sources
    input wire logic [DW-1:0] status_flags,
    input wire logic [DW-1:0] status_mask,
    // device pins and controls
    input wire logic          irq_n_o_ff,
    input wire logic          irq_n_oe_n_ff,
    input wire logic          processor_clock_out_pin_ff,
    input wire logic          xtal_oscillator_disable_ff,
    input wire logic          autoboot_stop_ff,
    input wire logic          results_ready_ff
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    logic ctrl_wr;
    logic irq_act;
    assign ctrl_wr = reg_req.wr && (reg_req.addr == ADDR_CTRL);
    assign irq_act = |(status_flags & status_mask);

    // ==========================================================
    // register port
    chk_read_answer: assert property (reg_req.rd |=> reg_rvalid_ff)
        else $error("read not answered one cycle later");
    chk_no_spurious: assert property (!reg_req.rd |=> !reg_rvalid_ff)
        else $error("read valid without a read");
    chk_rdata_hold: assert property (!reg_req.rd |=> $stable(reg_rdata_ff))
        else $error("read data moved without a read");
    // ==========================================================
    // control pins
    chk_xtal_follow: assert property (ctrl_wr |-> ##2
        (xtal_oscillator_disable_ff == $past(reg_req.wdata[CTRL_XTAL_OFF_BIT], 2)))
        else $error("oscillator disable does not follow control write");
    chk_stop_follow: assert property (ctrl_wr |-> ##2
        (autoboot_stop_ff == $past(reg_req.wdata[CTRL_STOP_BIT], 2)))
        else $error("autoboot stop does not follow control write");
    chk_cpu_quiet: assert property (ctrl_wr && reg_req.wdata[CTRL_CLKOUT_OFF_BIT] |->
        ##2 (!processor_clock_out_pin_ff) [*4])
        else $error("processor clock pin runs while disabled");
    // ==========================================================
    // interrupt pin and result sequencer
    chk_irq_assert: assert property (irq_act |=> !irq_n_o_ff && !irq_n_oe_n_ff)
        else $error("interrupt pin not driven low while active");
    chk_irq_idle: assert property (!irq_act |=> irq_n_o_ff || irq_n_oe_n_ff)
        else $error("interrupt pin low while inactive");
    chk_ready_pulse: assert property (results_ready_ff |=> !results_ready_ff)
        else $error("results ready longer than one cycle");

    cover property (ctrl_wr && reg_req.wdata[CTRL_IRQOD_BIT]);
    cover property (results_ready_ff);
    cover property (irq_act ##1 !irq_n_oe_n_ff);
endmodule

bind prcr_regs prcr_regs_asserts #(.CYC_W(CYC_W), .CLK_DIV(CLK_DIV)) u_chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata_ff(reg_rdata_ff),
    .reg_rvalid_ff(reg_rvalid_ff), .status_flags(status_flags), .status_mask(status_mask),
    .irq_n_o_ff(irq_n_o_ff), .irq_n_oe_n_ff(irq_n_oe_n_ff),
    .processor_clock_out_pin_ff(processor_clock_out_pin_ff),
    .xtal_oscillator_disable_ff(xtal_oscillator_disable_ff),
    .autoboot_stop_ff(autoboot_stop_ff), .results_ready_ff(results_ready_ff));

// File: tb/prcr_host.sv
// host processor model driving the register port
`timescale 1ns/100ps
module prcr_host
    import prcr_pkg::*;
(
    // clock
    input  wire logic          sys_clk,
    // register port
    output prcr_reg_req_t      reg_req,
    input  wire logic [DW-1:0] reg_rdata_ff,
    input  wire logic          reg_rvalid_ff
);
    initial reg_req = '0;

    // hold the request to its taking edge, then release with qualifiers low and inverted address and data
    task automatic put(input logic w, input logic r, input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge sys_clk);
        reg_req <= '{wr: w, rd: r, addr: a, wdata: d};
        @(posedge sys_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask

    // the page register shares 0x1f, so the host never writes there
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        if (a != ADDR_Q_FUND) put(1'b1, 1'b0, a, d);
    endtask

    task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d, output logic ok);
        put(1'b0, 1'b1, a, 24'h000000);
        #1;
        ok = reg_rvalid_ff;
        d  = reg_rdata_ff;
    endtask
endmodule

// File: tb/prcr_regs_tb.sv
// self-checking testbench of the power result and control register bank
`timescale 1ns/100ps
module prcr_regs_tb
    import prcr_pkg::*;
;
    logic          sys_clk, rst_n, sample_valid;
    prcr_sample_t  sample;
    prcr_dft_t     dft;
    prcr_reg_req_t reg_req;
    logic [DW-1:0] active_power, vrms, irms, status_flags, status_mask, rdata;
    logic [23:0]   cycle_count;
    logic          rvalid, irq_o, irq_oe_n, cpu_pin, xtal_off, stop, ready;
    int            miscompares = 0;
    int            num_checks = 0;

    prcr_regs dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata_ff(rdata),
        .reg_rvalid_ff(rvalid), .sample_valid(sample_valid), .sample(sample), .dft(dft),
        .active_power(active_power), .vrms(vrms), .irms(irms), .cycle_count(cycle_count),
        .status_flags(status_flags), .status_mask(status_mask), .irq_n_o_ff(irq_o),
        .irq_n_oe_n_ff(irq_oe_n), .processor_clock_out_pin_ff(cpu_pin),
        .xtal_oscillator_disable_ff(xtal_off), .autoboot_stop_ff(stop), .results_ready_ff(ready));
    prcr_host host (.sys_clk(sys_clk), .reg_req(reg_req), .reg_rdata_ff(rdata), .reg_rvalid_ff(rvalid));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // ==========================================================
    // compare and control helpers
    task automatic chk_word(input string name, input logic [DW-1:0] exp, input logic [DW-1:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chk_bit(input string name, input logic exp, input logic got);
        chk_word(name, {23'h0, exp}, {23'h0, got});
    endtask
    task automatic rd_chk(input logic [AW-1:0] a, input logic [DW-1:0] exp, input string name);
        logic [DW-1:0] d;
        logic          ok;
        host.rd(a, d, ok);
        chk_bit("read valid", 1'b1, ok);
        chk_word(name, exp, d);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic put_sample(input logic [DW-1:0] i, input logic [DW-1:0] v, input logic [DW-1:0] q);
        @(posedge sys_clk);
        sample_valid <= 1'b1;
        sample       <= '{i_smp: i, v_smp: v, v_q90: q};
        @(posedge sys_clk);
        sample_valid <= 1'b0;
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset();
        rd_chk(ADDR_CTRL, CTRL_RESET, "ctrl reset");
        rd_chk(5'h1a, 24'h000000, "unmapped read");
        chk_bit("stop reset", 1'b0, stop);
        chk_bit("xtal reset", 1'b0, xtal_off);
    endtask
    task automatic t_ctrl();
        int seen;
        host.wr(ADDR_CTRL, 24'hffffff);
        rd_chk(ADDR_CTRL, CTRL_WMASK, "ctrl masked");
        chk_bit("stop set", 1'b1, stop);
        chk_bit("xtal set", 1'b1, xtal_off);
        seen = 0;
        repeat (8) begin cycles(1); seen += cpu_pin; end
        chk_bit("cpu clock stopped", 1'b0, seen != 0);
        host.wr(ADDR_CTRL, 24'h000000);
        cycles(2);
        chk_bit("stop clear", 1'b0, stop);
        seen = 0;
        repeat (8) begin cycles(1); seen += cpu_pin; end
        chk_bit("cpu clock runs", 1'b1, seen != 0);
    endtask
    task automatic t_results();
        int n;
        put_sample(24'h400000, 24'h100000, 24'h200000);
        rd_chk(ADDR_Q_INST, 24'h100000, "q instant 1");
        put_sample(24'hb00000, 24'ha00000, 24'hc00000);
        for (n = 0; n < 400 && ready !== 1'b1; n++) cycles(1);
        if (n == 400) begin miscompares++; wrap_up(); end
        rd_chk(ADDR_Q_INST, 24'h280000, "q instant 2");
        rd_chk(ADDR_REACT_AVG, 24'h1c0000, "q average");
        rd_chk(ADDR_I_PEAK, 24'hb00000, "i peak");
        rd_chk(ADDR_V_PEAK, 24'ha00000, "v peak");
        rd_chk(ADDR_Q_TRIG, 24'h200000, "q trig");
        rd_chk(ADDR_PWR_FACTOR, 24'h4ccccc, "power factor");
        rd_chk(ADDR_S, 24'h280000, "apparent");
        rd_chk(ADDR_P_HARM, 24'hf80000, "harmonic");
        rd_chk(ADDR_P_FUND, 24'h200000, "fund active");
        rd_chk(ADDR_Q_FUND, 24'hf00000, "fund reactive");
        host.wr(ADDR_Q_INST, 24'h123456);
        host.wr(ADDR_PWR_FACTOR, 24'h654321);
        rd_chk(ADDR_Q_INST, 24'h280000, "q instant kept");
        rd_chk(ADDR_PWR_FACTOR, 24'h4ccccc, "factor kept");
    endtask
    task automatic t_irq();
        @(posedge sys_clk);
        status_mask  <= 24'h000001;
        status_flags <= 24'h000001;
        cycles(2);
        chk_bit("irq low", 1'b0, irq_o);
        chk_bit("irq driven", 1'b0, irq_oe_n);
        @(posedge sys_clk) status_mask <= 24'h000000;
        cycles(2);
        chk_bit("irq high", 1'b1, irq_o);
        chk_bit("irq drives high", 1'b0, irq_oe_n);
        host.wr(ADDR_CTRL, 24'h000010);
        cycles(2);
        chk_bit("irq released", 1'b1, irq_oe_n);
        @(posedge sys_clk) status_mask <= 24'h000001;
        cycles(2);
        chk_bit("od irq low", 1'b0, irq_o);
        chk_bit("od irq driven", 1'b0, irq_oe_n);
    endtask

    initial begin
        rst_n        = 1'b0;
        sample_valid = 1'b0;
        sample       = '0;
        dft          = '{v_re: 24'h400000, v_im: 24'h000000, i_re: 24'h400000, i_im: 24'h200000};
        active_power = 24'h180000;
        vrms         = 24'h400000;
        irms         = 24'h500000;
        cycle_count  = 24'h000002;
        status_flags = 24'h000000;
        status_mask  = 24'h000000;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        t_ctrl();
        t_results();
        t_irq();
        wrap_up();
    end
endmodule
